/* File: sarps_defines.svh */
`ifndef SARPS_DEFINES_SVH
`define SARPS_DEFINES_SVH

// ****************************************************************
// Register map.
// ****************************************************************
`define SARPS_ADDR_W 8
`define SARPS_OFF_CTRL 8'h00
`define SARPS_OFF_STATUS 8'h04
`define SARPS_OFF_RESULT 8'h08
`define SARPS_OFF_INT_STAT 8'h0c
`define SARPS_OFF_INT_MASK 8'h10

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define SARPS_CTRL_ENABLE 0
`define SARPS_CTRL_RESET 1'b1
`define SARPS_INT_W 3
`define SARPS_INT_DONE 0
`define SARPS_INT_READ 1
`define SARPS_INT_IGNORED 2
`define SARPS_INT_MASK_RESET 3'h0
`define SARPS_STAT_STATE_LSB 0
`define SARPS_STAT_SHUTDOWN 4
`define SARPS_STAT_REF_ON 5
`define SARPS_STAT_POWERED 6
`define SARPS_STAT_EOC 7

// ****************************************************************
// Timing.
// ****************************************************************
`define SARPS_CLK_PERIOD_NS 10
`define SARPS_CONV_TIME_NS 4700
`define SARPS_CONV_CYCLES (`SARPS_CONV_TIME_NS / `SARPS_CLK_PERIOD_NS)
`define SARPS_RES_BITS 16
`define SARPS_BIT_CYCLES ((`SARPS_CONV_CYCLES - 6) / (`SARPS_RES_BITS + 1))
`define SARPS_TICK_W 5

`endif

/* File: sarps_pkg.sv */
package sarps_pkg;

    // Sequencer states, Gray coded from IDLE to READ; the return from READ to IDLE flips two bits.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ACQ = 3'h1,
        ST_CONV = 3'h3,
        ST_DONE = 3'h2,
        ST_READ = 3'h6
    } sarps_state_e;

endpackage

/* File: sarps_sync.sv */
`timescale 1ns/1ns

module sarps_sync #(
    parameter int WIDTH = 4
) (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] async_in, // Signals from outside the clock domain.
    output logic [WIDTH-1:0] sync_out // Synchronised copies.
);

    logic [WIDTH-1:0] meta;

    // Two flip-flops per bit; only the second stage is read outside.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta[i] <= 1'b1;
                    sync_out[i] <= 1'b1;
                end else begin
                    meta[i] <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule

/* File: sarps_sar.sv */
`timescale 1ns/1ns
`include "sarps_defines.svh"

module sarps_sar (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic start, // One-cycle pulse that begins a conversion.
    input wire logic comp_in, // Synchronised comparator, high when input exceeds trial.
    output logic busy, // High while a conversion runs.
    output logic done, // One-cycle pulse when the result is final.
    output logic [15:0] result, // Final conversion code.
    output logic [15:0] trial // Trial code driven to the capacitive DAC.
);

    localparam logic [4:0] BIT_LAST = 5'(`SARPS_BIT_CYCLES - 1);

    logic [4:0] tick;
    logic [3:0] bit_idx;

    // Decision for the bit under test, and the trial for the next bit.
    wire tick_end = busy && (tick == BIT_LAST);
    wire [15:0] bit_mask = 16'h0001 << bit_idx;
    wire [15:0] kept = comp_in ? trial : (trial & ~bit_mask);
    wire [15:0] next_trial = kept | (bit_mask >> 1);

    // Each bit gets a fixed settle slot so the whole conversion stays
    // inside the maximum conversion time, with margin for the sync delay.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            done <= 1'b0;
            tick <= 5'h00;
            bit_idx <= 4'h0;
            trial <= 16'h0000;
            result <= 16'h0000;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy <= 1'b1;
                tick <= 5'h00;
                bit_idx <= 4'hf;
                trial <= 16'h8000;
            end else if (tick_end) begin
                tick <= 5'h00;
                trial <= next_trial;
                if (bit_idx == 4'h0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    result <= kept;
                end else begin
                    bit_idx <= bit_idx - 4'h1;
                end
            end else if (busy) begin
                tick <= tick + 5'h01;
            end
        end
    end

endmodule

/* File: sarps_seq.sv */
`timescale 1ns/1ns
`include "sarps_defines.svh"

// Behaviour
// - Drive conversion-done low once the result is ready to read.
// - Present the 16-bit result over a byte-wide bus, two halves multiplexed.
// - High-byte select 1 shows the upper byte, 0 the lower byte.
// - Bit 0 of the lower byte is the LSB, result bit 15 the MSB.
// - First strobe fall with select low powers up and starts acquisition.
// - Second strobe fall holds the sample and begins conversion.
// - Third strobe fall with select high puts the result on the bus.
// - Select at second fall picks standby or shutdown after conversion.
// - Select high at second fall means shutdown, low means standby.
// - Conversion clock is generated internally, none comes from the host.
// - Conversion-done asserts within 4.7 us of the second strobe fall.
// - Bus is high-impedance in acquisition, conversion, and after strobe rises.
// - A first strobe fall with select high is ignored.
module sarps_seq (
    input wire logic pclk, // Clock, 100 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic [31:0] paddr, // APB address.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic strobe_n, // Convert strobe pin, active low.
    input wire logic read_convert, // Read/convert select pin.
    input wire logic high_byte_select, // High-byte select pin.
    input wire logic comp_in, // Comparator from the analog front end.
    output logic eoc_n, // Conversion-done, active low.
    output logic [7:0] data_out, // Byte-wide result bus, bit 0 is data_out_bit0_bit8.
    output logic data_oe_n, // Bus output enable, low while driving.
    output logic [15:0] dac_code, // Trial code to the capacitive DAC.
    output logic hold, // High while the track-and-hold switches are open.
    output logic core_on, // Converter core powered.
    output logic ref_on, // Reference and buffer powered.
    output logic irq // Level interrupt.
);

    // ****************************************************************
    // Pin synchronisation and strobe edge detection.
    // ****************************************************************

    logic [3:0] pins_s;
    logic strobe_prev;

    // Pins are asynchronous to pclk; two flops per pin keep a
    // metastable first stage away from the sequencer. The cost is
    // a fixed lag that the host sees on every pin.
    sarps_sync #(.WIDTH(4)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({comp_in, high_byte_select, read_convert, strobe_n}),
        .sync_out(pins_s)
    );

    // Bundle order: strobe, select, byte select, comparator.
    wire strobe_s = pins_s[0];
    wire rc_s = pins_s[1];
    wire hbs_s = pins_s[2];
    wire comp_s = pins_s[3];

    // Resetting high, the strobe's idle level, keeps the release
    // of reset from looking like a falling edge.
    // Edge memory, fed only from the second sync stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_prev <= 1'b1;
        end else begin
            strobe_prev <= strobe_s;
        end
    end

    // One-cycle pulses, two cycles after the pin moves.
    wire strobe_fall = strobe_prev && !strobe_s;
    wire strobe_rise = !strobe_prev && strobe_s;

    // ****************************************************************
    // Successive-approximation engine on the internal clock.
    // ****************************************************************

    logic sar_done;
    logic [15:0] sar_result;
    logic sar_start;

    // Start and done are one-cycle pulses; in between the engine
    // owns dac_code. Its slot is a fixed count, so the conversion
    // time scales with the pclk period.
    // The bit timing is derived from pclk here; the host supplies no clock.
    sarps_sar u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .start(sar_start),
        .comp_in(comp_s),
        .busy(),
        .done(sar_done),
        .result(sar_result),
        .trial(dac_code)
    );

    // ****************************************************************
    // Registers.
    // ****************************************************************

    // enable gates only a new first edge, never a running cycle.
    // shutdown holds the mode picked at the second edge.
    // result keeps the last code until the next conversion ends.
    sarps_pkg::sarps_state_e state;
    sarps_pkg::sarps_state_e next_state;
    logic enable;
    logic shutdown;
    logic [15:0] result;
    logic [`SARPS_INT_W-1:0] int_stat;
    logic [`SARPS_INT_W-1:0] int_mask;

    // ****************************************************************
    // Sequencer.
    // ****************************************************************

    // Every edge is qualified by the state, so a fall that fits
    // no state is dropped and never advances the cycle.
    // A first fall with select high is flagged, not acted upon.
    // Edge meaning depends on the state; the select level is taken with the edge.
    wire first_ok = (state == sarps_pkg::ST_IDLE) && strobe_fall && !rc_s && enable;
    wire first_bad = (state == sarps_pkg::ST_IDLE) && strobe_fall && rc_s;
    wire second = (state == sarps_pkg::ST_ACQ) && strobe_fall;
    wire third = (state == sarps_pkg::ST_DONE) && strobe_fall && rc_s;
    wire conv_edge = (state == sarps_pkg::ST_CONV) && strobe_fall;
    wire read_end = (state == sarps_pkg::ST_READ) && strobe_rise;

    // Conversion starts on the edge that opens the switches.
    assign sar_start = second;

    // next_state also steers the bus flops, so the bus turns on
    // in the same cycle as the read state.
    // A strobe fall in CONV matches no transition, so the state stays put.
    always_comb begin
        next_state = state;
        case (state)
            sarps_pkg::ST_IDLE: begin
                if (first_ok) begin
                    next_state = sarps_pkg::ST_ACQ;
                end
            end
            sarps_pkg::ST_ACQ: begin
                if (second) begin
                    next_state = sarps_pkg::ST_CONV;
                end
            end
            sarps_pkg::ST_CONV: begin
                if (sar_done) begin
                    next_state = sarps_pkg::ST_DONE;
                end
            end
            sarps_pkg::ST_DONE: begin
                if (third) begin
                    next_state = sarps_pkg::ST_READ;
                end
            end
            sarps_pkg::ST_READ: begin
                if (read_end) begin
                    next_state = sarps_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = sarps_pkg::ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= sarps_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Power-mode choice is latched at the second edge and applied at the end.
    // The choice is the select level seen with the second fall.
    // core_on always drops after a conversion; only the
    // reference follows the standby or shutdown choice.
    wire next_shutdown = second ? rc_s : shutdown;
    wire next_core_on = first_ok ? 1'b1 : (sar_done ? 1'b0 : core_on);
    wire next_ref_on = first_ok ? 1'b1 : (sar_done ? !shutdown : ref_on);
    wire next_hold = second ? 1'b1 : (sar_done ? 1'b0 : hold);

    // Conversion-done falls with the result and rises when the read ends.
    // A new cycle starts only from idle, so it cannot start while a result is unread.
    wire next_eoc_n = sar_done ? 1'b0 : ((read_end || first_ok) ? 1'b1 : eoc_n);

    // Result stored once, bit 0 is the LSB and bit 15 the MSB.
    // It moves only on done, so a read never sees it change.
    wire [15:0] next_result = sar_done ? sar_result : result;

    // Byte steering follows the select live while the bus is driven.
    // The byte select is synchronised like the strobe, so a new
    // byte shows about three cycles after the pin moves.
    wire [7:0] byte_sel = hbs_s ? result[15:8] : result[7:0];
    wire driving = (next_state == sarps_pkg::ST_READ);
    // A released bus reads zero, never a stale byte.
    wire [7:0] next_data_out = driving ? byte_sel : 8'h00;

    // Pin-side outputs are flops, so no decode glitch escapes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutdown <= 1'b0;
            core_on <= 1'b0;
            ref_on <= 1'b0;
            hold <= 1'b0;
            eoc_n <= 1'b1;
            result <= 16'h0000;
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
        end else begin
            shutdown <= next_shutdown;
            core_on <= next_core_on;
            ref_on <= next_ref_on;
            hold <= next_hold;
            eoc_n <= next_eoc_n;
            result <= next_result;
            data_out <= next_data_out;
            data_oe_n <= !driving;
        end
    end

    // ****************************************************************
    // Interrupt status and mask.
    // ****************************************************************

    // Flags: done, read finished, ignored fall.
    // Any unmasked flag holds the interrupt high.
    wire [`SARPS_INT_W-1:0] int_set = {first_bad || conv_edge, read_end, sar_done};
    // Writes land on the edge that ends the access, with pready high.
    wire wr_access = psel && penable && pwrite && pready;
    // Only the low address byte is decoded; higher bits alias.
    wire [7:0] addr = paddr[7:0];
    wire hit_ctrl = (addr == `SARPS_OFF_CTRL);
    wire hit_status = (addr == `SARPS_OFF_STATUS);
    wire hit_result = (addr == `SARPS_OFF_RESULT);
    wire hit_istat = (addr == `SARPS_OFF_INT_STAT);
    wire hit_imask = (addr == `SARPS_OFF_INT_MASK);
    // hit_any drives pslverr; an unmapped write changes nothing.
    wire hit_any = hit_ctrl || hit_status || hit_result || hit_istat || hit_imask;
    // A zero bit in the write data leaves that flag alone.
    wire [`SARPS_INT_W-1:0] int_clr = (wr_access && hit_istat) ? pwdata[`SARPS_INT_W-1:0] : '0;

    // A new event outweighs a write-one-to-clear in the same cycle.
    wire [`SARPS_INT_W-1:0] next_int_stat = (int_stat & ~int_clr) | int_set;
    wire [`SARPS_INT_W-1:0] next_int_mask =
        (wr_access && hit_imask) ? pwdata[`SARPS_INT_W-1:0] : int_mask;
    // Clearing enable blocks new cycles but aborts none.
    wire next_enable = (wr_access && hit_ctrl) ? pwdata[`SARPS_CTRL_ENABLE] : enable;

    // irq reads the next values so it moves with the flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat <= '0;
            int_mask <= `SARPS_INT_MASK_RESET;
            enable <= `SARPS_CTRL_RESET;
            irq <= 1'b0;
        end else begin
            int_stat <= next_int_stat;
            int_mask <= next_int_mask;
            enable <= next_enable;
            irq <= |(next_int_stat & next_int_mask);
        end
    end

    // ****************************************************************
    // APB slave, one wait state on every access.
    // ****************************************************************

    // An unmapped address reads zero and raises pslverr.
    // Reads are assembled from live state so status shows the block as it runs.
    wire [31:0] status_word = {24'h0, !eoc_n, core_on, ref_on, shutdown, 1'b0, state};
    // Fields sit in the low bits; the rest reads zero.
    wire [31:0] rd_word =
        hit_ctrl ? {31'h0, enable} :
        hit_status ? status_word :
        hit_result ? {16'h0, result} :
        hit_istat ? {29'h0, int_stat} :
        hit_imask ? {29'h0, int_mask} : 32'h0;
    // An access is taken once, in its first access cycle.
    wire access = psel && penable && !pready;

    // The registered ready costs a cycle but keeps every output off a gate.
    // prdata is zero outside the answer cycle, so stale data
    // never lingers on the bus.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= access;
            pslverr <= access && !hit_any;
            prdata <= (access && !pwrite) ? rd_word : 32'h0;
        end
    end

endmodule

/* File: sarps_seq_sva.sv */
`timescale 1ns/1ns

// ****************************************************************
// Checker on the pin side of the sequencer.
// ****************************************************************
module sarps_seq_chk (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic hold, // Track-and-hold open.
    input wire logic eoc_n, // Conversion-done, active low.
    input wire logic data_oe_n, // Bus output enable, active low.
    input wire logic [7:0] data_out, // Result byte.
    input wire logic [15:0] dac_code, // Trial code.
    input wire logic core_on // Core powered.
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A conversion runs from the opening of the switches to their closing.
    sequence conv_start;
        $rose(hold);
    endsequence
    sequence conv_end;
        $fell(hold);
    endsequence

    // The bounds leave a few cycles for the output registers to follow.
    a_done_at_end: assert property (conv_end |-> ##[0:4] !eoc_n)
        else $error("conversion-done missing at end of conversion");
    a_done_in_time: assert property (conv_start |-> ##[1:466] !eoc_n)
        else $error("conversion-done later than the conversion limit");
    a_bus_quiet_hold: assert property (hold |-> data_oe_n)
        else $error("data bus driven during conversion");
    a_read_after_done: assert property (!data_oe_n |-> !eoc_n)
        else $error("data bus driven without a finished result");
    a_idle_bus_zero: assert property (data_oe_n |-> data_out == 8'h00)
        else $error("data byte not zero while bus released");
    a_conv_first_trial: assert property (conv_start |-> ##[0:2] dac_code == 16'h8000)
        else $error("conversion did not start from the midscale trial");
    a_powered_in_hold: assert property (hold |-> core_on)
        else $error("core unpowered during conversion");
    a_internal_clock: assert property (conv_start |-> ##[1:60] dac_code != $past(dac_code))
        else $error("trial code does not advance on its own");
    a_core_off_after: assert property (conv_end |-> ##[0:4] !core_on)
        else $error("core still powered after conversion");
    a_release_done: assert property ($rose(data_oe_n) |-> ##[0:6] eoc_n)
        else $error("conversion-done not withdrawn after read");
endmodule

bind sarps_seq sarps_seq_chk chk_u (.pclk(pclk), .presetn(presetn), .hold(hold), .eoc_n(eoc_n),
    .data_oe_n(data_oe_n), .data_out(data_out), .dac_code(dac_code), .core_on(core_on));

/* File: sarps_host.sv */
`timescale 1ns/1ns

// ****************************************************************
// Host processor on the strobe and byte bus.
// ****************************************************************
module sarps_host (
    input wire logic pclk, // Clock.
    input wire logic eoc_n, // Conversion-done from the converter.
    output logic strobe_n, // Convert strobe, active low.
    output logic read_convert, // Read/convert select.
    output logic high_byte_select, // Byte select.
    output logic take // High in the cycle before a byte is sampled.
);
    // Idle lines: strobe high, nothing being sampled.
    initial begin
        strobe_n = 1'b1;
        read_convert = 1'b0;
        high_byte_select = 1'b0;
        take = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Select is held well around the fall, since the pins are sampled late.
    task automatic pulse(input logic rc);
        read_convert <= rc;
        wait_clk(2);
        strobe_n <= 1'b0;
        wait_clk(6);
        strobe_n <= 1'b1;
        wait_clk(6);
    endtask

    // Acquire, convert with the chosen mode, and optionally strobe mid-conversion.
    task automatic convert(input logic mode, input logic poke, output logic ok);
        pulse(1'b0);
        pulse(mode);
        if (poke) begin
            pulse(1'b1);
        end
        ok = 1'b0;
        for (int i = 0; i < 1000 && !ok; i++) begin
            wait_clk(1);
            ok = (eoc_n === 1'b0);
        end
    endtask

    // Third fall: read the low byte, then the high byte, then release.
    task automatic read_both();
        read_convert <= 1'b1;
        wait_clk(2);
        strobe_n <= 1'b0;
        wait_clk(6);
        for (int h = 0; h < 2; h++) begin
            high_byte_select <= h[0];
            wait_clk(6);
            take <= 1'b1;
            wait_clk(1);
            take <= 1'b0;
        end
        strobe_n <= 1'b1;
        wait_clk(8);
    endtask
endmodule

/* File: test_sar_adc_parallel_sequencer.sv */
`timescale 1ns/1ns
`include "sarps_defines.svh"

module test_sar_adc_parallel_sequencer;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, comp_in, take, ok;
    logic strobe_n, read_convert, high_byte_select, eoc_n, data_oe_n, hold, core_on, ref_on, irq;
    logic [31:0] paddr, pwdata, prdata;
    logic [7:0] data_out;
    logic [15:0] dac_code, ain;
    logic [31:0] exp_q[$];
    string what_q[$];
    int failures, checks_done;

    sarps_seq dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .strobe_n(strobe_n), .read_convert(read_convert),
        .high_byte_select(high_byte_select), .comp_in(comp_in), .eoc_n(eoc_n),
        .data_out(data_out), .data_oe_n(data_oe_n), .dac_code(dac_code), .hold(hold),
        .core_on(core_on), .ref_on(ref_on), .irq(irq));
    sarps_host host_u (.pclk(pclk), .eoc_n(eoc_n), .strobe_n(strobe_n),
        .read_convert(read_convert), .high_byte_select(high_byte_select), .take(take));

    // ****************************************************************
    // Checking and reporting.
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic note(input string what, input logic [31:0] exp);
        what_q.push_back(what);
        exp_q.push_back(exp);
    endtask

    task automatic take_note(input logic [31:0] seen);
        if (exp_q.size() == 0) begin
            failures++;
            $display("[FAIL] unexpected result expected none seen %h", seen);
        end else begin
            check(what_q.pop_front(), seen, exp_q.pop_front());
        end
    endtask

    task automatic conclude();
        failures += exp_q.size();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Results are matched to the oldest note when a read completes or a byte is taken.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            take_note(prdata);
        end
        if (take === 1'b1) begin
            take_note({23'h0, data_oe_n, data_out});
        end
    end

    // Comparator sees the input half a code above ain, so either sense of a tie gives ain.
    always @(posedge pclk) begin
        comp_in <= ({ain, 1'b1} > {dac_code, 1'b0});
    end

    // ****************************************************************
    // Register bus master.
    // ****************************************************************
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n = 0;
        paddr <= {24'h0, addr};
        pwrite <= wr;
        pwdata <= wd;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            $display("[FAIL] pready expected 1 seen 0");
        end
        check("pslverr", {31'h0, pslverr}, {31'h0, addr > `SARPS_OFF_INT_MASK});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] addr, input string what, input logic [31:0] exp);
        note(what, exp);
        apb(1'b0, addr, 32'h0);
    endtask

    // ****************************************************************
    // Clock, watchdog and test sequence.
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Two conversions of about 450 cycles plus register traffic fit well inside this.
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        $display("[FAIL] run length expected finish seen timeout");
        conclude();
    end

    // Main sequence.
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        ain = 16'h0;
        failures = 0;
        checks_done = 0;
        void'($urandom(16));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SARPS_OFF_CTRL, "ctrl reset", 32'h1);
        rd(`SARPS_OFF_STATUS, "status reset", 32'h0);
        rd(`SARPS_OFF_INT_STAT, "int_stat reset", 32'h0);
        rd(`SARPS_OFF_INT_MASK, "int_mask reset", 32'h0);
        rd(8'h14, "unmapped read", 32'h0);
        host_u.pulse(1'b1);
        rd(`SARPS_OFF_STATUS, "status after select-high fall", 32'h0);
        rd(`SARPS_OFF_INT_STAT, "ignored fall flag", 32'h4);
        check("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, `SARPS_OFF_INT_STAT, 32'h7);
        apb(1'b1, `SARPS_OFF_INT_MASK, 32'h7);
        apb(1'b1, `SARPS_OFF_CTRL, 32'h0);
        rd(`SARPS_OFF_CTRL, "ctrl cleared", 32'h0);
        host_u.pulse(1'b0);
        rd(`SARPS_OFF_STATUS, "status while disabled", 32'h0);
        apb(1'b1, `SARPS_OFF_CTRL, 32'h1);
        rd(`SARPS_OFF_INT_STAT, "int_stat cleared", 32'h0);
        for (int m = 0; m < 2; m++) begin
            ain = 16'($urandom());
            host_u.convert(m[0], m[0], ok);
            check("done before limit", {31'h0, ok}, 32'h1);
            check("ref_on pin", {31'h0, ref_on}, {31'h0, !m[0]});
            rd(`SARPS_OFF_STATUS, "status done", m ? 32'h92 : 32'ha2);
            rd(`SARPS_OFF_RESULT, "result", {16'h0, ain});
            rd(`SARPS_OFF_INT_STAT, "done flag", m ? 32'h5 : 32'h1);
            check("irq raised", {31'h0, irq}, 32'h1);
            note("low byte", {24'h0, ain[7:0]});
            note("high byte", {24'h0, ain[15:8]});
            host_u.read_both();
            rd(`SARPS_OFF_INT_STAT, "read flag", m ? 32'h7 : 32'h3);
            apb(1'b1, `SARPS_OFF_INT_STAT, 32'h7);
            @(posedge pclk);
            check("irq cleared", {31'h0, irq}, 32'h0);
        end
        conclude();
    end
endmodule
